// file: logic/crsf_core_regs.v
`include "crsf_regs.vh"
`default_nettype none
module crsf_core_regs #(
  parameter PC_W  = 23,
  parameter ACC_W = 40
) (
  input  wire        i_clock,
  input  wire        i_rst,
  input  wire [5:0]  i_mem_addr,
  input  wire        i_mem_we,
  input  wire [1:0]  i_mem_be,
  input  wire [15:0] i_mem_wdata,
  output reg  [15:0] o_mem_rdata,
  input  wire        i_wr_en,
  input  wire [3:0]  i_wr_idx,
  input  wire [15:0] i_wr_data,
  input  wire        i_wr_byte,
  input  wire        i_acc_we,
  input  wire        i_acc_sel,
  input  wire [39:0] i_acc_data,
  input  wire        i_sp_push,
  input  wire        i_sp_pop,
  input  wire        i_exc_entry,
  output reg  [15:0] o_exc_word,
  input  wire        i_pc_load,
  input  wire [22:0] i_pc_target,
  input  wire        i_pc_inc,
  output wire [22:0] o_pc,
  input  wire        i_shadow_save,
  input  wire        i_shadow_restore,
  input  wire        i_loop_start,
  input  wire [22:0] i_loop_first,
  input  wire [15:0] i_loop_offset,
  input  wire [15:0] i_loop_count,
  input  wire        i_loop_end,
  input  wire        i_repeat_start,
  input  wire        i_repeat_end,
  input  wire        i_flag_we,
  input  wire        i_carry_in_op,
  input  wire [4:0]  i_alu_flags,
  input  wire [2:0]  i_ovf_set,
  input  wire [1:0]  i_sat_set,
  input  wire [2:0]  i_ipl_in,
  input  wire        i_ipl_we,
  input  wire        i_issue,
  input  wire [2:0]  i_flow_class,
  output wire        o_busy,
  output reg  [1:0]  o_last_cycles,
  output wire [15:0] o_status
);
  reg [15:0] work_reg [0:15];
  reg [15:0] shadow_reg [0:3];
  reg [39:0] acc_reg [0:1];
  reg [22:0] pc_reg;
  reg [7:0]  tblpg_reg;
  reg [7:0]  psvpg_reg;
  reg [15:0] rcnt_reg;
  reg [15:0] dcnt_reg;
  reg [22:0] dfirst_reg;
  reg [22:0] dlast_reg;
  reg [15:0] dcnt_sh_reg;
  reg [22:0] dfirst_sh_reg;
  reg [22:0] dlast_sh_reg;
  reg [15:0] status_reg;
  reg [15:0] status_sh_reg;
  reg [1:0]  cyc_left_reg;
  reg [1:0]  cyc_next;
  reg [15:0] st_next;
  reg [15:0] wmask;
  integer    i;

  function [15:0] merge16;
    input [15:0] old;
    input [15:0] new_val;
    input [1:0]  be;
    begin
      merge16 = {be[1] ? new_val[15:8] : old[15:8], be[0] ? new_val[7:0] : old[7:0]};
    end
  endfunction

  wire mem_wr = i_mem_we & (i_mem_be != 2'h0);
  wire st_mem_wr = mem_wr & (i_mem_addr == `CRSF_A_STATUS);
  assign o_status = status_reg;
  assign o_pc = {pc_reg[22:1], 1'b0};
  assign o_busy = (cyc_left_reg > `CRSF_CYC_ONE);

  always @* begin
    case (i_mem_addr)
      `CRSF_A_ACC1_L:   o_mem_rdata = acc_reg[0][15:0];
      `CRSF_A_ACC1_H:   o_mem_rdata = acc_reg[0][31:16];
      `CRSF_A_ACC1_U:   o_mem_rdata = {8'h00, acc_reg[0][39:32]};
      `CRSF_A_ACC2_L:   o_mem_rdata = acc_reg[1][15:0];
      `CRSF_A_ACC2_H:   o_mem_rdata = acc_reg[1][31:16];
      `CRSF_A_ACC2_U:   o_mem_rdata = {8'h00, acc_reg[1][39:32]};
      `CRSF_A_PC_L:     o_mem_rdata = {pc_reg[15:1], 1'b0};
      `CRSF_A_PC_H:     o_mem_rdata = {9'h000, pc_reg[22:16]};
      `CRSF_A_TBLPG:    o_mem_rdata = {8'h00, tblpg_reg};
      `CRSF_A_PSVPG:    o_mem_rdata = {8'h00, psvpg_reg};
      `CRSF_A_RCNT:     o_mem_rdata = rcnt_reg;
      `CRSF_A_DCNT:     o_mem_rdata = dcnt_reg;
      `CRSF_A_DFIRST_L: o_mem_rdata = dfirst_reg[15:0];
      `CRSF_A_DFIRST_H: o_mem_rdata = {9'h000, dfirst_reg[22:16]};
      `CRSF_A_DLAST_L:  o_mem_rdata = dlast_reg[15:0];
      `CRSF_A_DLAST_H:  o_mem_rdata = {9'h000, dlast_reg[22:16]};
      `CRSF_A_STATUS:   o_mem_rdata = status_reg;
      default: begin
        if (i_mem_addr[5:4] == 2'h0) begin
          o_mem_rdata = work_reg[i_mem_addr[3:0]];
        end else begin
          o_mem_rdata = 16'h0000;
        end
      end
    endcase
  end

  // Status next value: software write first, then hardware events override.
  always @* begin
    st_next = status_reg;
    wmask = {i_mem_be[1] ? 8'hff : 8'h00, i_mem_be[0] ? 8'hff : 8'h00};
    if (st_mem_wr && !i_flag_we) begin
      st_next = (status_reg & ~(`CRSF_SW_MASK & wmask)) | (i_mem_wdata & `CRSF_SW_MASK & wmask);
      if (wmask[`CRSF_B_DA] && !i_mem_wdata[`CRSF_B_DA]) st_next[`CRSF_B_DA] = 1'b0;
      if (wmask[`CRSF_B_SA] && !i_mem_wdata[`CRSF_B_SA]) st_next[`CRSF_B_SA] = 1'b0;
      if (wmask[`CRSF_B_SB] && !i_mem_wdata[`CRSF_B_SB]) st_next[`CRSF_B_SB] = 1'b0;
      if (wmask[`CRSF_B_SAB] && !i_mem_wdata[`CRSF_B_SAB]) begin
        st_next[`CRSF_B_SAB] = 1'b0;
        st_next[`CRSF_B_SA] = 1'b0;
        st_next[`CRSF_B_SB] = 1'b0;
      end
    end
    if (i_shadow_restore) begin
      st_next = (st_next & ~`CRSF_SHADOW_MASK) | (status_sh_reg & `CRSF_SHADOW_MASK);
    end
    if (i_flag_we) begin
      st_next[`CRSF_B_C]  = i_alu_flags[0];
      st_next[`CRSF_B_N]  = i_alu_flags[2];
      st_next[`CRSF_B_DC] = i_alu_flags[3];
      if (i_carry_in_op) begin
        st_next[`CRSF_B_Z] = st_next[`CRSF_B_Z] & i_alu_flags[1];
      end else begin
        st_next[`CRSF_B_Z] = i_alu_flags[1];
      end
      st_next[`CRSF_B_OV] = i_alu_flags[4];
    end
    if (i_ovf_set[0]) st_next[`CRSF_B_OA] = 1'b1;
    if (i_ovf_set[1]) st_next[`CRSF_B_OB] = 1'b1;
    st_next[`CRSF_B_OAB] = st_next[`CRSF_B_OA] | st_next[`CRSF_B_OB];
    // Saturation sets win over a same-cycle software clear.
    if (i_sat_set[0]) st_next[`CRSF_B_SA] = 1'b1;
    if (i_sat_set[1]) st_next[`CRSF_B_SB] = 1'b1;
    if (|i_sat_set) st_next[`CRSF_B_SAB] = 1'b1;
    if (i_ipl_we) st_next[`CRSF_B_IPL+2:`CRSF_B_IPL] = i_ipl_in;
    if (i_repeat_end) st_next[`CRSF_B_RA] = 1'b0;
    if (i_repeat_start) st_next[`CRSF_B_RA] = 1'b1;
    if (i_loop_end) st_next[`CRSF_B_DA] = 1'b0;
    if (i_loop_start) st_next[`CRSF_B_DA] = 1'b1;
  end

  always @* begin
    cyc_next = (cyc_left_reg != 2'h0) ? cyc_left_reg - `CRSF_CYC_ONE : 2'h0;
    if (i_issue && !o_busy) begin
      case (i_flow_class)
        `CRSF_F_NORMAL:  cyc_next = `CRSF_CYC_ONE;
        `CRSF_F_JUMP:    cyc_next = `CRSF_CYC_TWO;
        `CRSF_F_RETURN:  cyc_next = `CRSF_CYC_THREE;
        `CRSF_F_DMOVE:   cyc_next = `CRSF_CYC_TWO;
        `CRSF_F_TABLE:   cyc_next = `CRSF_CYC_TWO;
        `CRSF_F_LONGJMP: cyc_next = `CRSF_CYC_TWO;
        `CRSF_F_LOOP:    cyc_next = `CRSF_CYC_TWO;
        `CRSF_F_STALL:   cyc_next = `CRSF_CYC_TWO;
        default:         cyc_next = `CRSF_CYC_ONE;
      endcase
    end
  end

  always @(posedge i_clock) begin
    if (i_rst) begin
      for (i = 0; i < 16; i = i + 1) work_reg[i] <= 16'h0000;
      for (i = 0; i < 4; i = i + 1) shadow_reg[i] <= 16'h0000;
      work_reg[`CRSF_SP_INDEX] <= `CRSF_SP_RESET;
      acc_reg[0] <= 40'h0000000000;
      acc_reg[1] <= 40'h0000000000;
      pc_reg <= 23'h000000;
      tblpg_reg <= 8'h00;
      psvpg_reg <= 8'h00;
      rcnt_reg <= 16'h0000;
      dcnt_reg <= 16'h0000;
      dfirst_reg <= 23'h000000;
      dlast_reg <= 23'h000000;
      dcnt_sh_reg <= 16'h0000;
      dfirst_sh_reg <= 23'h000000;
      dlast_sh_reg <= 23'h000000;
      status_reg <= 16'h0000;
      status_sh_reg <= 16'h0000;
      o_exc_word <= 16'h0000;
      cyc_left_reg <= 2'h0;
      o_last_cycles <= 2'h0;
    end else begin
      status_reg <= st_next;
      cyc_left_reg <= cyc_next;
      if (i_issue && !o_busy) o_last_cycles <= cyc_next;
      if (mem_wr && i_mem_addr[5:4] == 2'h0) begin
        work_reg[i_mem_addr[3:0]] <= merge16(work_reg[i_mem_addr[3:0]], i_mem_wdata, i_mem_be);
      end
      if (i_wr_en) begin
        work_reg[i_wr_idx] <= i_wr_byte ? {work_reg[i_wr_idx][15:8], i_wr_data[7:0]} : i_wr_data;
      end
      if (i_sp_push) work_reg[`CRSF_SP_INDEX] <= work_reg[`CRSF_SP_INDEX] + 16'h0002;
      if (i_sp_pop) work_reg[`CRSF_SP_INDEX] <= work_reg[`CRSF_SP_INDEX] - 16'h0002;
      work_reg[`CRSF_SP_INDEX][0] <= 1'b0;
      if (i_shadow_save) begin
        for (i = 0; i < 4; i = i + 1) shadow_reg[i] <= work_reg[i];
        status_sh_reg <= status_reg & `CRSF_SHADOW_MASK;
      end
      if (i_shadow_restore) begin
        for (i = 0; i < 4; i = i + 1) work_reg[i] <= shadow_reg[i];
      end
      if (i_exc_entry) begin
        o_exc_word <= {1'b0, pc_reg[22:16], status_reg[7:0]};
      end
      if (i_acc_we) acc_reg[i_acc_sel] <= i_acc_data;
      if (mem_wr) begin
        case (i_mem_addr)
          `CRSF_A_ACC1_L: acc_reg[0][15:0] <= merge16(acc_reg[0][15:0], i_mem_wdata, i_mem_be);
          `CRSF_A_ACC1_H: acc_reg[0][31:16] <= merge16(acc_reg[0][31:16], i_mem_wdata, i_mem_be);
          `CRSF_A_ACC1_U: if (i_mem_be[0]) acc_reg[0][39:32] <= i_mem_wdata[7:0];
          `CRSF_A_ACC2_L: acc_reg[1][15:0] <= merge16(acc_reg[1][15:0], i_mem_wdata, i_mem_be);
          `CRSF_A_ACC2_H: acc_reg[1][31:16] <= merge16(acc_reg[1][31:16], i_mem_wdata, i_mem_be);
          `CRSF_A_ACC2_U: if (i_mem_be[0]) acc_reg[1][39:32] <= i_mem_wdata[7:0];
          `CRSF_A_TBLPG:  if (i_mem_be[0]) tblpg_reg <= i_mem_wdata[7:0];
          `CRSF_A_PSVPG:  if (i_mem_be[0]) psvpg_reg <= i_mem_wdata[7:0];
          `CRSF_A_RCNT:   rcnt_reg <= merge16(rcnt_reg, i_mem_wdata, i_mem_be);
          `CRSF_A_DCNT:   dcnt_reg <= merge16(dcnt_reg, i_mem_wdata, i_mem_be);
          default: begin
          end
        endcase
      end
      // Loop shadows are not mapped, so only the loop events reach them.
      if (i_loop_start) begin
        dcnt_sh_reg <= dcnt_reg;
        dfirst_sh_reg <= dfirst_reg;
        dlast_sh_reg <= dlast_reg;
        dcnt_reg <= i_loop_count;
        dfirst_reg <= i_loop_first;
        dlast_reg <= i_loop_first + {{7{i_loop_offset[15]}}, i_loop_offset};
      end else if (i_loop_end) begin
        dcnt_reg <= dcnt_sh_reg;
        dfirst_reg <= dfirst_sh_reg;
        dlast_reg <= dlast_sh_reg;
      end
      if (i_pc_load) begin
        pc_reg <= {i_pc_target[22:1], 1'b0};
      end else if (i_pc_inc) begin
        pc_reg <= pc_reg + 23'h000002;
      end
    end
  end
endmodule
`default_nettype wire

// file: logic/crsf_regs.vh
`ifndef CRSF_REGS_VH
`define CRSF_REGS_VH
`define CRSF_SP_RESET    16'h0800
`define CRSF_SP_INDEX    4'hf
`define CRSF_ADDR_W      6
// Word indices of the memory-mapped core registers.
`define CRSF_A_ACC1_L    6'h10
`define CRSF_A_ACC1_H    6'h11
`define CRSF_A_ACC1_U    6'h12
`define CRSF_A_ACC2_L    6'h13
`define CRSF_A_ACC2_H    6'h14
`define CRSF_A_ACC2_U    6'h15
`define CRSF_A_PC_L      6'h16
`define CRSF_A_PC_H      6'h17
`define CRSF_A_TBLPG     6'h18
`define CRSF_A_PSVPG     6'h19
`define CRSF_A_RCNT      6'h1a
`define CRSF_A_DCNT      6'h1b
`define CRSF_A_DFIRST_L  6'h1c
`define CRSF_A_DFIRST_H  6'h1d
`define CRSF_A_DLAST_L   6'h1e
`define CRSF_A_DLAST_H   6'h1f
`define CRSF_A_STATUS    6'h20
// Status word bit positions.
`define CRSF_B_C     0
`define CRSF_B_Z     1
`define CRSF_B_OV    2
`define CRSF_B_N     3
`define CRSF_B_RA    4
`define CRSF_B_IPL   5
`define CRSF_B_DC    8
`define CRSF_B_DA    9
`define CRSF_B_SAB   10
`define CRSF_B_OAB   11
`define CRSF_B_SB    12
`define CRSF_B_SA    13
`define CRSF_B_OB    14
`define CRSF_B_OA    15
// Mask of bits that a shadow save or restore moves.
`define CRSF_SHADOW_MASK 16'h010f
// Mask of bits software can write directly (c, z, n, ipl, dc).
`define CRSF_SW_MASK     16'h01eb
// Instruction flow classes and their cycle counts.
`define CRSF_F_NORMAL  3'h0
`define CRSF_F_JUMP    3'h1
`define CRSF_F_RETURN  3'h2
`define CRSF_F_DMOVE   3'h3
`define CRSF_F_TABLE   3'h4
`define CRSF_F_LONGJMP 3'h5
`define CRSF_F_LOOP    3'h6
`define CRSF_F_STALL   3'h7
`define CRSF_CYC_ONE   2'h1
`define CRSF_CYC_TWO   2'h2
`define CRSF_CYC_THREE 2'h3
`endif

// file: verification/crsf_checker.sv
`default_nettype none
module crsf_checker (
  input wire logic        i_clock,
  input wire logic        i_rst,
  input wire logic [5:0]  i_mem_addr,
  input wire logic        i_mem_we,
  input wire logic        i_flag_we,
  input wire logic        i_carry_in_op,
  input wire logic        i_shadow_restore,
  input wire logic        i_exc_entry,
  input wire logic        i_repeat_start,
  input wire logic        i_loop_start,
  input wire logic [2:0]  i_ovf_set,
  input wire logic        i_issue,
  input wire logic [2:0]  i_flow_class,
  input wire logic [15:0] o_mem_rdata,
  input wire logic [15:0] o_exc_word,
  input wire logic [22:0] o_pc,
  input wire logic        o_busy,
  input wire logic [1:0]  o_last_cycles,
  input wire logic [15:0] o_status
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  wire logic [15:0] exc_exp = {1'b0, o_pc[22:16], o_status[7:0]};
  wire logic        st_wr   = i_mem_we && (i_mem_addr == 6'h20);
  a_sp_even: assert property (i_mem_addr == 6'h0f |-> o_mem_rdata[0] == 1'b0) else $error("sp bit0 set");
  a_pc_even: assert property (o_pc[0] == 1'b0) else $error("pc bit0 set");
  a_exc_word: assert property (i_exc_entry |=> o_exc_word == $past(exc_exp)) else $error("bad exc word");
  a_ra_set: assert property (i_repeat_start |=> o_status[4]) else $error("ra not set");
  a_ra_hold: assert property (!o_status[4] && !i_repeat_start |=> !o_status[4]) else $error("ra set");
  a_da_hold: assert property (!o_status[9] && !i_loop_start |=> !o_status[9]) else $error("da set");
  a_sat_sticky: assert property (o_status[13] && !st_wr |=> o_status[13]) else $error("sa lost");
  a_oa_only: assert property (!o_status[15] && !i_ovf_set[0] |=> !o_status[15]) else $error("oa set");
  a_z_and: assert property (
    i_flag_we && i_carry_in_op && !o_status[1] && !i_shadow_restore |=> !o_status[1])
    else $error("z set by carry op");
  a_ret_three: assert property (i_issue && !o_busy && i_flow_class == 3'h2 |=>
    o_last_cycles == 2'h3 && o_busy ##1 o_busy ##1 !o_busy) else $error("return cycles");
  a_jump_two: assert property (i_issue && !o_busy && i_flow_class == 3'h1 |=>
    o_last_cycles == 2'h2 && o_busy ##1 !o_busy) else $error("jump cycles");
  c_ret: cover property (i_issue && i_flow_class == 3'h2);
  c_sat: cover property (o_status[13] && st_wr);
  c_loop: cover property (i_loop_start);
endmodule
bind crsf_core_regs crsf_checker u_chk (.i_clock, .i_rst, .i_mem_addr, .i_mem_we, .i_flag_we, .i_carry_in_op,
  .i_shadow_restore, .i_exc_entry, .i_repeat_start, .i_loop_start, .i_ovf_set, .i_issue, .i_flow_class,
  .o_mem_rdata, .o_exc_word, .o_pc, .o_busy, .o_last_cycles, .o_status);
`default_nettype wire

// file: verification/core_registers_status_flow_tb.sv
`default_nettype none
module core_registers_status_flow_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clock, i_rst, i_mem_we, i_wr_en, i_wr_byte, i_acc_we, i_acc_sel, i_sp_push, i_sp_pop, i_exc_entry;
  logic i_pc_load, i_pc_inc, i_shadow_save, i_shadow_restore, i_loop_start, i_loop_end, i_repeat_start;
  logic i_repeat_end, i_flag_we, i_carry_in_op, i_ipl_we, i_issue, o_busy;
  logic [5:0]  i_mem_addr;
  logic [1:0]  i_mem_be, i_sat_set, o_last_cycles;
  logic [15:0] i_mem_wdata, i_wr_data, i_loop_offset, i_loop_count, o_mem_rdata, o_exc_word, o_status;
  logic [3:0]  i_wr_idx;
  logic [39:0] i_acc_data;
  logic [22:0] i_pc_target, i_loop_first, o_pc;
  logic [4:0]  i_alu_flags;
  logic [2:0]  i_ovf_set, i_ipl_in, i_flow_class;
  int errors = 0;
  int cmp_count = 0;
  int n;
  // Each row is {address, byte enables, write data, expected read back}.
  logic [39:0] rows [7] = '{{6'h01, 2'h3, 16'h1234, 16'h1234}, {6'h0f, 2'h3, 16'h1235, 16'h1234},
    {6'h02, 2'h2, 16'habcd, 16'hab00}, {6'h10, 2'h3, 16'h5a5a, 16'h5a5a}, {6'h20, 2'h3, 16'hffff, 16'h01eb},
    {6'h16, 2'h3, 16'h1234, 16'h0000}, {6'h3f, 2'h3, 16'hffff, 16'h0000}};
  logic [1:0]  ncyc [8] = '{2'h1, 2'h2, 2'h3, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2};
  crsf_core_regs #(.PC_W(23), .ACC_W(40)) DUT (.i_clock, .i_rst, .i_mem_addr, .i_mem_we, .i_mem_be,
    .i_mem_wdata, .o_mem_rdata, .i_wr_en, .i_wr_idx, .i_wr_data, .i_wr_byte, .i_acc_we, .i_acc_sel,
    .i_acc_data, .i_sp_push, .i_sp_pop, .i_exc_entry, .o_exc_word, .i_pc_load, .i_pc_target, .i_pc_inc,
    .o_pc, .i_shadow_save, .i_shadow_restore, .i_loop_start, .i_loop_first, .i_loop_offset, .i_loop_count,
    .i_loop_end, .i_repeat_start, .i_repeat_end, .i_flag_we, .i_carry_in_op, .i_alu_flags, .i_ovf_set,
    .i_sat_set, .i_ipl_in, .i_ipl_we, .i_issue, .i_flow_class, .o_busy, .o_last_cycles, .o_status);
  initial begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end
  task automatic summarize;
    if (errors == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [1:0] be, input logic [15:0] d);
    i_mem_addr = a;
    i_mem_be = be;
    i_mem_wdata = d;
    i_mem_we = 1'b1;
    @(negedge i_clock);
    i_mem_we = 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [15:0] exp);
    i_mem_addr = a;
    #1 chk("rdata", o_mem_rdata, exp);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge i_clock);
    s = 1'b0;
  endtask
  task automatic do_reset;
    i_rst = 1'b1;
    repeat (2) @(negedge i_clock);
    i_rst = 1'b0;
  endtask
  initial begin
    #100us;
    errors++;
    summarize();
  end
  initial begin
    {i_mem_we, i_wr_en, i_wr_byte, i_acc_we, i_acc_sel, i_sp_push, i_sp_pop, i_exc_entry, i_pc_load, i_pc_inc,
     i_shadow_save, i_shadow_restore, i_loop_start, i_loop_end, i_repeat_start, i_repeat_end, i_flag_we,
     i_carry_in_op, i_ipl_we, i_issue, i_mem_addr, i_mem_be, i_sat_set, i_mem_wdata, i_wr_data, i_loop_offset,
     i_loop_count, i_wr_idx, i_acc_data, i_pc_target, i_loop_first, i_alu_flags, i_ovf_set, i_ipl_in,
     i_flow_class} = '0;
    do_reset();
    foreach (rows[i]) begin
      wr(rows[i][39:34], rows[i][33:32], rows[i][31:16]);
      rd(rows[i][39:34], rows[i][15:0]);
    end
    do_reset();
    rd(6'h0f, 16'h0800);
    rd(6'h20, 16'h0000);
    pulse(i_sp_push);
    rd(6'h0f, 16'h0802);
    pulse(i_sp_pop);
    rd(6'h0f, 16'h0800);
    wr(6'h03, 2'h3, 16'h1234);
    i_wr_idx = 4'h3;
    i_wr_data = 16'h00ff;
    i_wr_byte = 1'b1;
    pulse(i_wr_en);
    rd(6'h03, 16'h12ff);
    wr(6'h00, 2'h3, 16'h1111);
    wr(6'h20, 2'h3, 16'h01eb);
    pulse(i_shadow_save);
    wr(6'h00, 2'h3, 16'h2222);
    wr(6'h20, 2'h3, 16'h0000);
    pulse(i_shadow_restore);
    rd(6'h00, 16'h1111);
    rd(6'h20, 16'h010b);
    i_loop_first = 23'h000100;
    i_loop_offset = 16'h0010;
    i_loop_count = 16'h0005;
    pulse(i_loop_start);
    rd(6'h1e, 16'h0110);
    chk("da", o_status[9], 1'b1);
    wr(6'h20, 2'h2, 16'h0200);
    chk("da", o_status[9], 1'b1);
    i_loop_count = 16'h0007;
    pulse(i_loop_start);
    pulse(i_loop_end);
    rd(6'h1b, 16'h0005);
    wr(6'h20, 2'h2, 16'h0000);
    wr(6'h20, 2'h2, 16'h0200);
    chk("da", o_status[9], 1'b0);
    pulse(i_repeat_start);
    wr(6'h20, 2'h3, 16'h0000);
    chk("ra", o_status[4], 1'b1);
    pulse(i_repeat_end);
    i_sat_set = 2'h3;
    @(negedge i_clock);
    i_sat_set = 2'h0;
    wr(6'h01, 2'h3, 16'h0000);
    chk("sat", o_status[13:10], 4'hd);
    wr(6'h20, 2'h2, 16'h3000);
    chk("sat", o_status[13:10], 4'h0);
    i_ovf_set = 3'h1;
    @(negedge i_clock);
    i_ovf_set = 3'h0;
    wr(6'h20, 2'h3, 16'h0000);
    chk("wrap", {o_status[15], o_status[11]}, 2'h3);
    i_alu_flags = 5'h02;
    i_flag_we = 1'b1;
    wr(6'h20, 2'h3, 16'h0001);
    i_flag_we = 1'b0;
    chk("cz", o_status[1:0], 2'h2);
    i_carry_in_op = 1'b1;
    i_alu_flags = 5'h00;
    pulse(i_flag_we);
    i_alu_flags = 5'h02;
    pulse(i_flag_we);
    chk("z", o_status[1], 1'b0);
    i_carry_in_op = 1'b0;
    pulse(i_flag_we);
    chk("z", o_status[1], 1'b1);
    i_ipl_in = 3'h5;
    pulse(i_ipl_we);
    chk("ipl", o_status[7:5], 3'h5);
    i_pc_target = 23'h012345;
    pulse(i_pc_load);
    chk("pc", o_pc, 23'h012344);
    pulse(i_pc_inc);
    chk("pc", o_pc, 23'h012346);
    pulse(i_exc_entry);
    chk("exc", o_exc_word, 16'h01a2);
    i_acc_sel = 1'b1;
    i_acc_data = 40'h123456789a;
    pulse(i_acc_we);
    rd(6'h13, 16'h789a);
    for (int c = 0; c < 8; c++) begin
      i_flow_class = c[2:0];
      pulse(i_issue);
      n = 0;
      while (o_busy === 1'b1 && n < 10) begin
        @(negedge i_clock);
        n++;
      end
      chk("busy", n, ncyc[c] - 1);
      chk("cycles", o_last_cycles, ncyc[c]);
    end
    summarize();
  end
endmodule
`default_nettype wire
